// File: design/smbe_top.sv
// spi master byte engine: data and control registers, shifter and pins
//
// Design decision made here: the plain strobed port.
module smbe_top (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // spi pins
    output logic            spi_sck,
    output logic            spi_mosi,
    input  wire logic       spi_miso,
    output logic            spi_out_bypass,
    // byte event
    output logic            spi_irq
);
    typedef struct packed {
        smbe_pkg::smbe_state_t fsm;
        logic [7:0]            shreg;
        logic [7:0]            txbuf;
        logic [7:0]            rxbuf;
        logic                  tx_buffer_full_flag;
        logic                  transfer_complete_flag;
        logic [1:0]            mode;
        logic                  clock_polarity_select;
        logic                  clock_phase_select;
        logic [1:0]            sel;
        logic [2:0]            bitcnt;
        logic                  sample;
        logic                  mosi;
        logic                  sck;
        logic                  drive;
        logic                  irq;
        logic [7:0]            rdata;
        logic [3:0]            leads;
    } smbe_core_st_t;

    smbe_core_st_t st_reg;
    smbe_core_st_t st_next;
    logic          miso_s;
    logic          bit_in;
    logic [7:0]    shifted;
    logic [7:0]    ctrl_image;
    logic          wr_data;
    logic          wr_ctrl;
    logic          start;
    logic          master;

    smbe_tim_if tim ();

    // ----------------------------------------
    // submodules
    // ----------------------------------------
    smbe_sync u_miso_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .din     (spi_miso),
        .dout    (miso_s)
    );

    smbe_sck_gen u_sck_gen (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .tim     (tim.gen)
    );

    assign tim.run      = (st_reg.fsm == smbe_pkg::ST_SHIFT);
    assign tim.rate_sel = st_reg.sel;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    assign wr_data = reg_wr && (reg_addr == smbe_pkg::ADDR_DATA);
    assign wr_ctrl = reg_wr && (reg_addr == smbe_pkg::ADDR_CTRL);
    assign master  = (st_reg.mode == smbe_pkg::MODE_MASTER);
    assign start   = (st_reg.fsm == smbe_pkg::ST_IDLE) && master && st_reg.tx_buffer_full_flag;
    assign bit_in  = st_reg.clock_phase_select ? miso_s : st_reg.sample;
    assign shifted = {st_reg.shreg[6:0], bit_in};

    always_comb begin
        ctrl_image                                 = '0;
        ctrl_image[smbe_pkg::TRANSFER_COMPLETE_FLAG_BIT]             = st_reg.transfer_complete_flag;
        ctrl_image[smbe_pkg::TBF_BIT]              = st_reg.tx_buffer_full_flag;
        ctrl_image[smbe_pkg::MODE_LSB +: 2]        = st_reg.mode;
        ctrl_image[smbe_pkg::CLOCK_POLARITY_SELECT_BIT]             = st_reg.clock_polarity_select;
        ctrl_image[smbe_pkg::CLOCK_PHASE_SELECT_BIT]             = st_reg.clock_phase_select;
        ctrl_image[smbe_pkg::SEL_LSB +: 2]         = st_reg.sel;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next       = st_reg;
        st_next.irq   = 1'b0;
        st_next.rdata = '0;

        // register reads, answer in the next cycle only
        if (reg_rd) begin
            case (reg_addr)
                smbe_pkg::ADDR_DATA: st_next.rdata = st_reg.rxbuf;
                smbe_pkg::ADDR_CTRL: st_next.rdata = ctrl_image;
                default:             st_next.rdata = '0;
            endcase
        end

        // control write, done flag cleared by writing zero
        if (wr_ctrl) begin
            st_next.mode = reg_wdata[smbe_pkg::MODE_LSB +: 2];
            st_next.clock_polarity_select = reg_wdata[smbe_pkg::CLOCK_POLARITY_SELECT_BIT];
            st_next.clock_phase_select = reg_wdata[smbe_pkg::CLOCK_PHASE_SELECT_BIT];
            st_next.sel  = reg_wdata[smbe_pkg::SEL_LSB +: 2];
            if (!reg_wdata[smbe_pkg::TRANSFER_COMPLETE_FLAG_BIT]) begin
                st_next.transfer_complete_flag = 1'b0;
            end
        end

        // shifter
        case (st_reg.fsm)
            smbe_pkg::ST_IDLE: begin
                if (start) begin
                    st_next.fsm    = smbe_pkg::ST_SHIFT;
                    st_next.shreg  = st_reg.txbuf;
                    st_next.tx_buffer_full_flag    = 1'b0;
                    st_next.bitcnt = '0;
                    st_next.leads  = '0;
                    if (!st_reg.clock_phase_select) begin
                        st_next.mosi = st_reg.txbuf[7];
                    end
                end
            end
            smbe_pkg::ST_SHIFT: begin
                if (!master) begin
                    st_next.fsm = smbe_pkg::ST_IDLE;
                end else begin
                    if (tim.lead) begin
                        st_next.leads = st_reg.leads + 4'h1;
                        if (!st_reg.clock_phase_select) begin
                            st_next.sample = miso_s;
                        end else begin
                            st_next.mosi = st_reg.shreg[7];
                        end
                    end
                    if (tim.bit_end) begin
                        st_next.shreg  = shifted;
                        st_next.bitcnt = st_reg.bitcnt + 3'h1;
                        if (st_reg.bitcnt == smbe_pkg::LAST_BIT) begin
                            st_next.fsm   = smbe_pkg::ST_IDLE;
                            st_next.rxbuf = shifted;
                            st_next.transfer_complete_flag  = 1'b1;
                            st_next.irq   = 1'b1;
                        end else if (!st_reg.clock_phase_select) begin
                            st_next.mosi = shifted[7];
                        end
                    end
                end
            end
            default: begin
                st_next.fsm = smbe_pkg::ST_IDLE;
            end
        endcase

        // data write last so a write beside a load is kept
        if (wr_data) begin
            st_next.txbuf = reg_wdata;
            st_next.tx_buffer_full_flag   = 1'b1;
        end

        st_next.sck   = st_reg.clock_polarity_select ^ ((st_reg.fsm == smbe_pkg::ST_SHIFT) && tim.seg_act);
        st_next.drive = master;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_reg     <= '0;
            st_reg.fsm <= smbe_pkg::ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata      = st_reg.rdata;
    assign spi_sck        = st_reg.sck;
    assign spi_mosi       = st_reg.mosi;
    assign spi_out_bypass = st_reg.drive;
    assign spi_irq        = st_reg.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_read_rx_buf: assert property (
        reg_rd && reg_addr == smbe_pkg::ADDR_DATA |=> reg_rdata == $past(st_reg.rxbuf))
        else $error("data read did not return receive buffer");

    a_no_self_start: assert property (
        $rose(st_reg.fsm == smbe_pkg::ST_SHIFT) |-> $past(st_reg.tx_buffer_full_flag) && $past(master))
        else $error("shift began without a pending byte");

    a_load_msb_first: assert property (
        start && !st_reg.clock_phase_select |=> spi_mosi == $past(st_reg.txbuf[7]) && st_reg.shreg == $past(st_reg.txbuf))
        else $error("msb not presented at byte start");

    a_duplex_shift: assert property (
        st_reg.fsm == smbe_pkg::ST_SHIFT && master && tim.bit_end
        |=> st_reg.shreg == {$past(st_reg.shreg[6:0]), $past(bit_in)})
        else $error("shift register did not take the sampled bit");

    a_rx_copy_done: assert property (
        spi_irq |-> st_reg.rxbuf == st_reg.shreg && st_reg.transfer_complete_flag && st_reg.fsm == smbe_pkg::ST_IDLE)
        else $error("byte end without receive copy");

    a_pending_waits: assert property (
        st_reg.fsm == smbe_pkg::ST_SHIFT && master && !tim.bit_end && !tim.lead
        |=> st_reg.shreg == $past(st_reg.shreg))
        else $error("shift register disturbed mid byte");

    a_wr_sets_tbf: assert property (
        wr_data |=> st_reg.tx_buffer_full_flag && st_reg.txbuf == $past(reg_wdata))
        else $error("buffer full flag or buffer not set by write");

    a_tbf_clears_load: assert property (
        start && !wr_data |=> !st_reg.tx_buffer_full_flag ##1 st_reg.fsm == smbe_pkg::ST_SHIFT)
        else $error("buffer full flag not cleared on load");

    a_eight_pulses: assert property (
        spi_irq |-> st_reg.leads == smbe_pkg::BYTE_EDGES)
        else $error("byte did not carry eight sck pulses");

    a_mode_field: assert property (
        wr_ctrl |=> st_reg.mode == $past(reg_wdata[smbe_pkg::MODE_LSB +: 2]))
        else $error("mode field not written");

    a_transfer_complete_flag_sticky: assert property (
        st_reg.transfer_complete_flag && !wr_ctrl |=> st_reg.transfer_complete_flag)
        else $error("complete flag cleared without software");

    a_sck_idle: assert property (
        st_reg.fsm == smbe_pkg::ST_IDLE |=> spi_sck == $past(st_reg.clock_polarity_select))
        else $error("sck not at idle level between bytes");
endmodule : smbe_top

// File: include/smbe_pkg.sv
// constants, types and decoding shared by the spi master byte engine
package smbe_pkg;

    // ----------------------------------------
    // clock and bit timing
    // ----------------------------------------
    localparam int CLK_MHZ      = 250;
    localparam int BIT_NS_R0    = 500;
    localparam int BIT_NS_R1    = 1000;
    localparam int BIT_NS_R2    = 2000;
    localparam int BIT_NS_R3    = 16000;
    localparam int BIT_CYC_R0   = BIT_NS_R0 * CLK_MHZ / 1000;
    localparam int BIT_CYC_R1   = BIT_NS_R1 * CLK_MHZ / 1000;
    localparam int BIT_CYC_R2   = BIT_NS_R2 * CLK_MHZ / 1000;
    localparam int BIT_CYC_R3   = BIT_NS_R3 * CLK_MHZ / 1000;
    localparam int FAST_ACT_CYC = (BIT_CYC_R0 + 2) / 3;

    // ----------------------------------------
    // register map and fields
    // ----------------------------------------
    localparam logic [7:0] ADDR_DATA  = 8'h60;
    localparam logic [7:0] ADDR_CTRL  = 8'h61;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int         TRANSFER_COMPLETE_FLAG_BIT   = 7;
    localparam int         TBF_BIT    = 6;
    localparam int         MODE_LSB   = 4;
    localparam int         CLOCK_POLARITY_SELECT_BIT   = 3;
    localparam int         CLOCK_PHASE_SELECT_BIT   = 2;
    localparam int         SEL_LSB    = 0;
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_MASTER = 2'h1;
    localparam logic [1:0] MODE_SLAVE  = 2'h2;
    localparam logic [1:0] SEL_FAST    = 2'h0;
    localparam logic [1:0] SEL_R1      = 2'h1;
    localparam logic [1:0] SEL_R2      = 2'h2;
    localparam logic [2:0] LAST_BIT    = 3'h7;
    localparam logic [3:0] BYTE_EDGES  = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } smbe_state_t;

    // ----------------------------------------
    // segment length: idle part then active part
    // ----------------------------------------
    function automatic logic [11:0] smbe_seg_len(input logic [1:0] sel, input logic act);
        logic [11:0] bit_c;
        logic [11:0] act_c;
        bit_c = 12'(BIT_CYC_R3);
        case (sel)
            SEL_FAST: bit_c = 12'(BIT_CYC_R0);
            SEL_R1:   bit_c = 12'(BIT_CYC_R1);
            SEL_R2:   bit_c = 12'(BIT_CYC_R2);
            default:  bit_c = 12'(BIT_CYC_R3);
        endcase
        act_c = (sel == SEL_FAST) ? 12'(FAST_ACT_CYC) : (bit_c >> 1);
        return act ? act_c : (bit_c - act_c);
    endfunction : smbe_seg_len

endpackage : smbe_pkg

// File: include/smbe_tim_if.sv
// timing link between the byte engine core and its sck generator
interface smbe_tim_if;
    logic       run;
    logic [1:0] rate_sel;
    logic       lead;
    logic       bit_end;
    logic       seg_act;

    modport gen (
        input  run,
        input  rate_sel,
        output lead,
        output bit_end,
        output seg_act
    );

    modport core (
        output run,
        output rate_sel,
        input  lead,
        input  bit_end,
        input  seg_act
    );
endinterface : smbe_tim_if

// File: design/smbe_sync.sv
// two flip-flop synchroniser for one level
module smbe_sync (
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // level
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } smbe_sync_st_t;

    smbe_sync_st_t st_reg;
    smbe_sync_st_t st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.s2;
endmodule : smbe_sync

// File: design/smbe_sck_gen.sv
// bit timer: idle segment then active segment per bit, with edge pulses
module smbe_sck_gen (
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // timing link
    smbe_tim_if.gen   tim
);
    localparam int FAST_HI_M1 = smbe_pkg::FAST_ACT_CYC - 1;

    typedef struct packed {
        logic [11:0] cnt;
        logic        seg;
        logic        lead;
        logic        bit_end;
    } smbe_gen_st_t;

    smbe_gen_st_t st_reg;
    smbe_gen_st_t st_next;

    // ----------------------------------------
    // segment counter
    // ----------------------------------------
    always_comb begin
        st_next         = st_reg;
        st_next.lead    = 1'b0;
        st_next.bit_end = 1'b0;
        if (!tim.run) begin
            st_next.cnt = '0;
            st_next.seg = 1'b0;
        end else if (st_reg.cnt == smbe_pkg::smbe_seg_len(tim.rate_sel, st_reg.seg) - 12'h001) begin
            st_next.cnt     = '0;
            st_next.seg     = !st_reg.seg;
            st_next.lead    = !st_reg.seg;
            st_next.bit_end = st_reg.seg;
        end else begin
            st_next.cnt = st_reg.cnt + 12'h001;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tim.lead    = st_reg.lead;
    assign tim.bit_end = st_reg.bit_end;
    assign tim.seg_act = st_reg.seg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_fast_active_len: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(st_reg.seg) && tim.rate_sel == smbe_pkg::SEL_FAST
        |-> ##FAST_HI_M1 (st_reg.seg || !tim.run) ##1 (!st_reg.seg || !tim.run))
        else $error("fast rate active segment length wrong");

    a_lead_then_end: assert property (@(posedge mclk) disable iff (sys_rst)
        st_reg.lead |-> !st_reg.bit_end ##1 (st_reg.seg || !tim.run))
        else $error("leading edge pulse without active segment");
endmodule : smbe_sck_gen

// File: verif/smbe_slave_model.sv
// behavioural spi slave facing the byte engine pins
module smbe_slave_model (
    // pins
    input  wire logic       spi_sck,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    input  wire logic       ss_n,
    // setup from bench
    input  wire logic       clock_polarity_select,
    input  wire logic       clock_phase_select,
    input  wire logic       slow,
    input  wire logic [7:0] tx_byte,
    // observations
    output logic      [7:0] rx_byte,
    output int              lead_cnt
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] sh;
    logic [7:0] acc;
    int         cnt;

    // ----------------------------------------
    // miso drive, prompt or slow
    // ----------------------------------------
    task automatic put(input logic v);
        spi_miso <= #(slow ? 100 : 2) v;
    endtask : put

    initial begin
        spi_miso = 1'b0;
        rx_byte  = 8'h00;
        lead_cnt = 0;
        sh       = 8'h00;
        acc      = 8'h00;
        cnt      = 0;
    end

    // select taken from a software pin of the bench
    always @(negedge ss_n) begin
        sh  = tx_byte;
        cnt = 0;
        put(tx_byte[7]);
    end

    // released line shows the inverse of its last level
    always @(posedge ss_n) begin
        put(~spi_miso);
    end

    // ----------------------------------------
    // shifting on sck edges
    // ----------------------------------------
    always @(spi_sck) begin
        if (!ss_n) begin
            if (spi_sck !== clock_polarity_select) begin
                lead_cnt++;
                if (!clock_phase_select) begin
                    acc = {acc[6:0], spi_mosi};
                end else begin
                    put(sh[7]);
                end
            end else begin
                if (clock_phase_select) begin
                    acc = {acc[6:0], spi_mosi};
                end
                sh = {sh[6:0], 1'b0};
                cnt++;
                if (cnt == 8) begin
                    rx_byte = acc;
                    sh      = tx_byte;
                    cnt     = 0;
                end
                if (!clock_phase_select) begin
                    put(sh[7]);
                end
            end
        end
    end
endmodule : smbe_slave_model

// File: verif/smbe_bench.sv
// self-checking bench for the spi master byte engine
module smbe_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic       mclk;
    logic       sys_rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       spi_sck;
    logic       spi_mosi;
    logic       spi_miso;
    logic       spi_out_bypass;
    logic       spi_irq;
    logic       ss_n;
    logic       m_clock_polarity_select;
    logic       m_clock_phase_select;
    logic       m_slow;
    logic [7:0] m_tx;
    logic [7:0] m_rx;
    int         m_leads;
    int         bad_count;
    int         cmp_count;

    smbe_top uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_out_bypass(spi_out_bypass), .spi_irq(spi_irq));

    // miso is an input of the block, slave select a bench pin
    smbe_slave_model slv (.spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .ss_n(ss_n), .clock_polarity_select(m_clock_polarity_select), .clock_phase_select(m_clock_phase_select), .slow(m_slow), .tx_byte(m_tx),
        .rx_byte(m_rx), .lead_cnt(m_leads));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ----------------------------------------
    // checks, bus cycles and waits
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_byte(what, {7'h00, exp}, {7'h00, got});
    endtask : chk_bit

    function automatic logic [7:0] ctl(input logic [1:0] m, input logic pol, input logic ph,
                                       input logic [1:0] sel);
        return {2'b00, m, pol, ph, sel};
    endfunction : ctl

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic wait_irq(input int limit, input logic pol, output int cyc, output int act);
        cyc = 0;
        act = 0;
        do begin
            @(posedge mclk);
            #1;
            cyc++;
            if (spi_sck !== pol) act++;
        end while (spi_irq !== 1'b1 && cyc < limit);
        if (spi_irq !== 1'b1) begin
            bad_count++;
            $display("mismatch spi_irq expected 1 seen %b", spi_irq);
            summarize();
        end
    endtask : wait_irq

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] v;
        chk_bit("sck", 1'b0, spi_sck);
        chk_bit("bypass", 1'b0, spi_out_bypass);
        rd(smbe_pkg::ADDR_DATA, v);
        chk_byte("data reset", 8'h00, v);
        wr(8'h62, 8'hff);
        rd(smbe_pkg::ADDR_CTRL, v);
        chk_byte("ctrl reset", 8'h00, v);
        rd(8'h62, v);
        chk_byte("unmapped", 8'h00, v);
        $display("done reset");
    endtask : t_reset

    task automatic t_mode_field();
        logic [7:0] v;
        logic [1:0] m;
        int         cyc;
        int         act;
        int         edges;
        ss_n <= 1'b0;
        m_tx <= 8'h3c;
        for (int i = 0; i < 4; i++) begin
            m = (i == 3) ? 2'h1 : ((i == 0) ? 2'h0 : 2'(i + 1));
            wr(smbe_pkg::ADDR_CTRL, ctl(m, 1'b0, 1'b0, 2'h0));
            if (m != smbe_pkg::MODE_MASTER) begin
                wr(smbe_pkg::ADDR_DATA, 8'h5a);
                edges = 0;
                repeat (300) begin
                    @(posedge mclk);
                    #1;
                    if (spi_sck !== 1'b0) edges++;
                end
                chk_bit("no start", 1'b1, edges == 0);
                rd(smbe_pkg::ADDR_CTRL, v);
                chk_bit("pending full", 1'b1, v[smbe_pkg::TBF_BIT]);
            end else begin
                wait_irq(2000, 1'b0, cyc, act);
                chk_byte("pending out", 8'h5a, m_rx);
            end
            chk_bit("bypass", m == smbe_pkg::MODE_MASTER, spi_out_bypass);
        end
        wr(smbe_pkg::ADDR_CTRL, ctl(smbe_pkg::MODE_MASTER, 1'b0, 1'b0, 2'h0));
        ss_n <= 1'b1;
        $display("done mode field");
    endtask : t_mode_field

    task automatic xfer(input logic [1:0] sel, input logic pol, input logic ph,
                        input logic [7:0] out, input logic [7:0] in);
        logic [7:0] v;
        logic       held;
        int         cyc;
        int         act;
        int         bitc;
        int         lead0;
        bitc = (sel == 2'h0) ? smbe_pkg::BIT_CYC_R0 : (sel == 2'h1) ? smbe_pkg::BIT_CYC_R1 :
               (sel == 2'h2) ? smbe_pkg::BIT_CYC_R2 : smbe_pkg::BIT_CYC_R3;
        m_clock_polarity_select <= pol;
        m_clock_phase_select <= ph;
        m_tx   <= in;
        wr(smbe_pkg::ADDR_CTRL, ctl(smbe_pkg::MODE_MASTER, pol, ph, sel));
        repeat (2) @(posedge mclk);
        ss_n   <= 1'b0;
        lead0 = m_leads;
        wr(smbe_pkg::ADDR_DATA, out);
        wait_irq(40000, pol, cyc, act);
        chk_bit("byte time", 1'b1, cyc >= 8 * bitc && cyc <= 8 * bitc + 10);
        held = spi_mosi;
        repeat (40) begin
            @(posedge mclk);
            #1;
            if (spi_sck !== pol) act++;
        end
        chk_bit("sck idle", pol, spi_sck);
        chk_bit("mosi held", held, spi_mosi);
        chk_bit("duty", 1'b1, act == 8 * ((sel == 2'h0) ? smbe_pkg::FAST_ACT_CYC : bitc / 2));
        chk_byte("sck pulses", 8'h08, 8'(m_leads - lead0));
        chk_byte("slave got", out, m_rx);
        rd(smbe_pkg::ADDR_DATA, v);
        chk_byte("rx buffer", in, v);
        @(posedge mclk);
        #1;
        chk_byte("rdata drop", 8'h00, reg_rdata);
        rd(smbe_pkg::ADDR_CTRL, v);
        chk_bit("done set", 1'b1, v[smbe_pkg::TRANSFER_COMPLETE_FLAG_BIT]);
        chk_bit("tbf clear", 1'b0, v[smbe_pkg::TBF_BIT]);
        wr(smbe_pkg::ADDR_CTRL, ctl(smbe_pkg::MODE_MASTER, pol, ph, sel));
        rd(smbe_pkg::ADDR_CTRL, v);
        chk_bit("done cleared", 1'b0, v[smbe_pkg::TRANSFER_COMPLETE_FLAG_BIT]);
        ss_n   <= 1'b1;
    endtask : xfer

    task automatic t_frames();
        for (int i = 0; i < 4; i++) begin
            m_slow <= i[0];
            xfer(2'(i), i[1], i[0], 8'hc3 ^ 8'(i), 8'h96 ^ 8'(i << 2));
        end
        $display("done frames");
    endtask : t_frames

    task automatic t_back2back();
        logic [7:0] v;
        int         cyc;
        int         act;
        int         hits;
        m_clock_polarity_select <= 1'b0;
        m_clock_phase_select <= 1'b0;
        m_slow <= 1'b0;
        m_tx   <= 8'h81;
        wr(smbe_pkg::ADDR_CTRL, ctl(smbe_pkg::MODE_MASTER, 1'b0, 1'b0, 2'h0));
        repeat (2) @(posedge mclk);
        ss_n   <= 1'b0;
        wr(smbe_pkg::ADDR_DATA, 8'he7);
        m_tx   <= 8'h4d;
        wr(smbe_pkg::ADDR_DATA, 8'h11);
        rd(smbe_pkg::ADDR_CTRL, v);
        chk_bit("tbf while busy", 1'b1, v[smbe_pkg::TBF_BIT]);
        wr(smbe_pkg::ADDR_DATA, 8'h72);
        wait_irq(2000, 1'b0, cyc, act);
        chk_byte("first out", 8'he7, m_rx);
        wait_irq(2000, 1'b0, cyc, act);
        chk_bit("back to back", 1'b1, cyc <= 8 * smbe_pkg::BIT_CYC_R0 + 10);
        chk_byte("replaced out", 8'h72, m_rx);
        rd(smbe_pkg::ADDR_DATA, v);
        chk_byte("overwritten rx", 8'h4d, v);
        hits = 0;
        repeat (1500) begin
            @(posedge mclk);
            #1;
            if (spi_irq !== 1'b0) hits++;
        end
        chk_bit("no third byte", 1'b1, hits == 0);
        ss_n   <= 1'b1;
        $display("done back to back");
    endtask : t_back2back

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        sys_rst   = 1'b1;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        ss_n      = 1'b1;
        m_clock_polarity_select    = 1'b0;
        m_clock_phase_select    = 1'b0;
        m_slow    = 1'b0;
        m_tx      = 8'h00;
        bad_count = 0;
        cmp_count = 0;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset();
        t_mode_field();
        t_frames();
        t_back2back();
        summarize();
    end
endmodule : smbe_bench
